// ---- awc_area_wait.sv ----
// Area 0/1 wait-state control register and the access pacing it steers
// Summary of operation
// [RQ1] Area 1 accesses with its wait enable set get the area 1 wait count.
// [RQ2] Area 0 accesses with its wait enable set get the area 0 wait count.
// [RQ3] Wait field is binary: zero gives no wait, N gives exactly N waits.
// [RQ4] Both reserved bits read zero and ignore writes.
// [RQ5] Reset sets both wait fields to all ones and reserved bits to zero.
// [RQ6] A clear wait enable makes that field ineffective, yet still read/write.
`timescale 1ns/1ps
module awc_area_wait (
   input wire logic clk,
   input wire logic rst,
   input wire awc_pkg::awc_bus_t bus,
   output logic [awc_pkg::DATA_W-1:0] rd_data_q,
   input wire awc_pkg::awc_acc_t acc,
   output logic acc_busy_q,
   output logic wait_state_q,
   output logic acc_done_q
);
   import awc_pkg::*;

   awc_wait_reg_t wait_reg_q, wait_reg_d;
   logic [1:0] wait_en_q, wait_en_d;
   logic [DATA_W-1:0] rd_data_d;
   awc_state_t state_q, state_d;
   logic area_q, area_d;
   logic [WAIT_W-1:0] waits_q, waits_d;
   logic [WAIT_W-1:0] left_q;
   logic accept;
   logic [WAIT_W-1:0] sel_field;
   logic sel_en;
   logic acc_busy_d, wait_state_d, acc_done_d;

   // Register file
   always_comb begin
      wait_reg_d = wait_reg_q;
      wait_en_d = wait_en_q;
      rd_data_d = '0;
      if (bus.wr && bus.addr == WAIT_CTRL_OFS) begin
         // Reserved positions stay zero whatever is written
         wait_reg_d.reserved1 = 1'b0; // [RQ4]
         wait_reg_d.reserved0 = 1'b0; // [RQ4]
         wait_reg_d.area1 = bus.wdata[AREA1_WAIT_LSB +: WAIT_W];
         wait_reg_d.area0 = bus.wdata[AREA0_WAIT_LSB +: WAIT_W];
      end
      if (bus.wr && bus.addr == ACC_STATE_OFS) begin
         wait_en_d = bus.wdata[1:0];
      end
      if (bus.rd) begin
         if (bus.addr == WAIT_CTRL_OFS) begin
            rd_data_d = wait_reg_q; // [RQ4] [RQ6]
         end else if (bus.addr == ACC_STATE_OFS) begin
            rd_data_d = {6'h00, wait_en_q};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wait_reg_q <= '{reserved1: 1'b0, area1: WAIT_RESET,
                         reserved0: 1'b0, area0: WAIT_RESET}; // [RQ5]
         wait_en_q <= ACC_STATE_RESET;
         rd_data_q <= '0;
      end else begin
         wait_reg_q <= wait_reg_d;
         wait_en_q <= wait_en_d;
         rd_data_q <= rd_data_d;
      end
   end

   // Access sequencing: T1, N program waits, T2
   assign accept = acc.req && state_q == ST_IDLE;
   assign sel_field = acc.area ? wait_reg_q.area1 : wait_reg_q.area0; // [RQ1] [RQ2]
   assign sel_en = acc.area ? wait_en_q[1] : wait_en_q[0];

   always_comb begin
      state_d = state_q;
      area_d = area_q;
      waits_d = waits_q;
      unique case (state_q)
         ST_IDLE: begin
            if (acc.req) begin
               state_d = ST_T1;
               area_d = acc.area;
               // Field snapshot at acceptance; later writes affect the next access
               waits_d = sel_en ? sel_field : NO_WAIT; // [RQ6]
            end
         end
         ST_T1: begin
            state_d = (waits_q != NO_WAIT) ? ST_TW : ST_T2; // [RQ3]
         end
         ST_TW: begin
            if (left_q == LAST_WAIT) begin
               state_d = ST_T2; // [RQ3]
            end
         end
         ST_T2: begin
            state_d = ST_IDLE;
         end
      endcase
      acc_busy_d = state_d != ST_IDLE;
      wait_state_d = state_d == ST_TW;
      acc_done_d = state_q == ST_T2;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         area_q <= 1'b0;
         waits_q <= NO_WAIT;
         acc_busy_q <= 1'b0;
         wait_state_q <= 1'b0;
         acc_done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         area_q <= area_d;
         waits_q <= waits_d;
         acc_busy_q <= acc_busy_d;
         wait_state_q <= wait_state_d;
         acc_done_q <= acc_done_d;
      end
   end

   // Loaded during T1 so the count is ready on the first wait cycle
   awc_wait_timer u_timer (
      .clk(clk),
      .rst(rst),
      .load(state_q == ST_T1),
      .load_val(waits_q),
      .run(state_q == ST_TW),
      .left_q(left_q)
   );

   // Checking helpers: wait cycles seen and wait count expected per access
   logic [3:0] tw_cnt_q;
   logic [WAIT_W-1:0] exp1_q, exp0_q;
   logic en1_q, en0_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         tw_cnt_q <= 4'h0;
         exp1_q <= NO_WAIT;
         exp0_q <= NO_WAIT;
         en1_q <= 1'b0;
         en0_q <= 1'b0;
      end else begin
         if (accept) begin
            tw_cnt_q <= 4'h0;
            exp1_q <= wait_reg_q.area1;
            exp0_q <= wait_reg_q.area0;
            en1_q <= wait_en_q[1];
            en0_q <= wait_en_q[0];
         end else if (wait_state_q) begin
            tw_cnt_q <= tw_cnt_q + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_area1_waits;
      $fell(acc_busy_q) && area_q && en1_q |-> tw_cnt_q == {1'b0, exp1_q};
   endproperty
   a_area1_waits: assert property (p_area1_waits) // [RQ1]
      else $error("area 1 wait count not honoured");

   property p_area0_waits;
      $fell(acc_busy_q) && !area_q && en0_q |-> tw_cnt_q == {1'b0, exp0_q};
   endproperty
   a_area0_waits: assert property (p_area0_waits) // [RQ2]
      else $error("area 0 wait count not honoured");

   property p_seven_waits;
      accept && sel_en && sel_field == 3'h7 |-> ##2 wait_state_q [*7] ##1 !wait_state_q
         ##1 acc_done_q;
   endproperty
   a_seven_waits: assert property (p_seven_waits) // [RQ3]
      else $error("all-ones field did not give seven waits");

   property p_zero_waits;
      accept && sel_en && sel_field == NO_WAIT |-> ##3 acc_done_q;
   endproperty
   a_zero_waits: assert property (p_zero_waits) // [RQ3]
      else $error("zero field still inserted waits");

   property p_reserved_zero;
      bus.rd && bus.addr == WAIT_CTRL_OFS |=> rd_data_q[7] == 1'b0 && rd_data_q[3] == 1'b0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [RQ4]
      else $error("reserved bit read as one");

   property p_reset_value;
      $past(rst) |-> wait_reg_q == 8'h77;
   endproperty
   a_reset_value: assert property (p_reset_value) // [RQ5]
      else $error("wait fields not all ones after reset");

   property p_disabled_no_wait;
      accept && !sel_en |-> ##1 !wait_state_q [*2] ##1 acc_done_q;
   endproperty
   a_disabled_no_wait: assert property (p_disabled_no_wait) // [RQ6]
      else $error("disabled area still inserted waits");

   property p_write_readback;
      bus.wr && bus.addr == WAIT_CTRL_OFS ##1 bus.rd && bus.addr == WAIT_CTRL_OFS
         |=> rd_data_q == ($past(bus.wdata, 2) & 8'h77);
   endproperty
   a_write_readback: assert property (p_write_readback) // [RQ6]
      else $error("wait field readback mismatch");

   property p_cov_waits1;
      accept && acc.area && sel_en && sel_field != NO_WAIT;
   endproperty
   c_waits1: cover property (p_cov_waits1);

   property p_cov_disabled0;
      accept && !acc.area && !sel_en;
   endproperty
   c_disabled0: cover property (p_cov_disabled0);

   property p_cov_write;
      bus.wr && bus.addr == WAIT_CTRL_OFS;
   endproperty
   c_write: cover property (p_cov_write);

endmodule // awc_area_wait

// ---- awc_pkg.sv ----
// Shared constants and types for the area wait-state configuration block
package awc_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   localparam logic [ADDR_W-1:0] WAIT_CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] ACC_STATE_OFS = 8'h01;

   localparam int unsigned AREA0_WAIT_LSB = 0;
   localparam int unsigned AREA1_WAIT_LSB = 4;
   localparam int unsigned WAIT_W = 3;

   localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h7;
   localparam logic [1:0] ACC_STATE_RESET = 2'h3;
   localparam logic [WAIT_W-1:0] NO_WAIT = 3'h0;
   localparam logic [WAIT_W-1:0] LAST_WAIT = 3'h1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } awc_bus_t;

   typedef struct packed {
      logic reserved1;
      logic [WAIT_W-1:0] area1;
      logic reserved0;
      logic [WAIT_W-1:0] area0;
   } awc_wait_reg_t;

   typedef struct packed {
      logic req;
      logic area;
   } awc_acc_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_T1,
      ST_TW,
      ST_T2
   } awc_state_t;

endpackage

// ---- awc_wait_timer.sv ----
// Down counter that paces the program wait states of one access
`timescale 1ns/1ps
module awc_wait_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [awc_pkg::WAIT_W-1:0] load_val,
   input wire logic run,
   output logic [awc_pkg::WAIT_W-1:0] left_q
);
   import awc_pkg::*;

   logic [WAIT_W-1:0] left_d;

   always_comb begin
      left_d = left_q;
      if (load) begin
         left_d = load_val;
      end else if (run && left_q != NO_WAIT) begin
         left_d = left_q - LAST_WAIT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         left_q <= NO_WAIT;
      end else begin
         left_q <= left_d;
      end
   end

endmodule // awc_wait_timer

// ---- awc_mem_model.sv ----
// Far-side memory model: counts the wait cycles it sees per access
`timescale 1ns/1ps
module awc_mem_model (
   input wire logic clk,
   input wire logic wait_state,
   input wire logic done,
   output int waits
);
   // Counter and result are 2-state, so both start at zero without a second driver
   int cnt = 0;
   always @(posedge clk) begin
      if (done) begin
         waits <= cnt;
         cnt <= 0;
      end else if (wait_state) begin
         cnt <= cnt + 1;
      end
   end
endmodule // awc_mem_model

// ---- testbench.sv ----
// Self-checking bench for the area wait-state configuration block
`timescale 1ns/1ps
module testbench;
   import awc_pkg::*;
   typedef struct {
      logic [7:0] w;
      logic [1:0] en;
      logic ar;
      logic [7:0] rb;
      int n;
   } awc_row_t;
   logic clk;
   logic rst;
   awc_bus_t bus;
   awc_acc_t acc;
   logic [7:0] rd_data_q;
   logic acc_busy_q;
   logic wait_state_q;
   logic acc_done_q;
   int mw;
   int n_mismatch = 0;
   int check_count = 0;
   // Reserved bits in the written values must come back as zero
   awc_row_t rows[8] = '{
      '{8'h00, 2'h3, 1'b0, 8'h00, 0}, '{8'hff, 2'h3, 1'b1, 8'h77, 7},
      '{8'h25, 2'h3, 1'b0, 8'h25, 5}, '{8'h25, 2'h3, 1'b1, 8'h25, 2},
      '{8'h25, 2'h1, 1'b1, 8'h25, 0}, '{8'h25, 2'h2, 1'b0, 8'h25, 0},
      '{8'hb9, 2'h3, 1'b1, 8'h31, 3}, '{8'hb9, 2'h3, 1'b0, 8'h31, 1}};

   awc_area_wait u_dut (.clk(clk), .rst(rst), .bus(bus), .rd_data_q(rd_data_q), .acc(acc),
      .acc_busy_q(acc_busy_q), .wait_state_q(wait_state_q), .acc_done_q(acc_done_q));
   awc_mem_model u_mem (.clk(clk), .wait_state(wait_state_q), .done(acc_done_q), .waits(mw));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chkn(input string nm, input int e, input int s);
      check_count++;
      if (s != e) begin
         n_mismatch++;
         $display("FAIL %s expected %0d seen %0d", nm, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask

   // Write then read with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      chk8("readback", e, rd_data_q);
      @(posedge clk);
   endtask

   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      chk8("read data", e, rd_data_q);
      @(posedge clk);
   endtask

   // Times the access from the taking edge to the done pulse
   task automatic acc_run(input logic ar, input int n);
      int c;
      int b;
      c = 0;
      b = 0;
      acc <= '{req: 1'b1, area: ar};
      @(posedge clk);
      acc <= '0;
      do begin
         @(negedge clk);
         c++;
         if (acc_busy_q === 1'b1)
            b++;
      end while (acc_done_q !== 1'b1 && c < 20);
      chkn("done cycle", n + 3, c);
      // Busy spans T1, the waits and T2, and is low in the done cycle
      chkn("busy cycles", n + 2, b);
      @(negedge clk);
      chkn("wait count", n, mw);
      @(posedge clk);
   endtask

   initial begin
      #200us;
      n_mismatch++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      bus = '0;
      acc = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(WAIT_CTRL_OFS, 8'h77);
      rd(ACC_STATE_OFS, 8'h03);
      acc_run(1'b0, 7);
      wr(8'h02, 8'hff);
      rd(8'h02, 8'h00);
      foreach (rows[i]) begin
         wr(ACC_STATE_OFS, {6'h3f, rows[i].en});
         wr_rd(WAIT_CTRL_OFS, rows[i].w, rows[i].rb);
         acc_run(rows[i].ar, rows[i].n);
      end
      // Mid-run reset must restore the all-ones wait fields
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(WAIT_CTRL_OFS, 8'h77);
      acc_run(1'b1, 7);
      conclude();
   end
endmodule // testbench
